// file: rtl/modem_pkg.sv
// shared constants and types for the modem core
package modem_pkg;
    localparam int CLK_HZ = 100000000;
    localparam int MARK_HZ = 1200;
    localparam int SPACE_HZ = 2200;
    localparam int TABLE_LEN = 32;
    localparam int SAMPLE_W = 6;
    localparam int IDX_W = 5;
    localparam int MARK_STEP = CLK_HZ / (MARK_HZ * TABLE_LEN);
    localparam int SPACE_STEP = CLK_HZ / (SPACE_HZ * TABLE_LEN);
    localparam int MAN_HZ = 31250;
    localparam int MAN_HALF = CLK_HZ / (MAN_HZ * 2);
    localparam int FSK_BAUD = 1200;
    localparam int FSK_BIT = CLK_HZ / FSK_BAUD;
    localparam int OSC_START_MS = 50;
    localparam int OSC_START_CYC = CLK_HZ / 1000 * OSC_START_MS;
    localparam int CD_ON_BITS = 6;
    localparam int CD_ON_CYC = FSK_BIT * CD_ON_BITS;
    localparam int CD_OFF_MS = 3;
    localparam int CD_OFF_CYC = CLK_HZ / 1000 * CD_OFF_MS;
    localparam int CNT_W = 24;
    localparam int FIFO_DEPTH = 8;
    localparam int LVL_W = 4;
    localparam int ST_CD_BIT = 1;
    localparam int ST_TXLVL_BIT = 4;
    localparam int ST_RXRDY_BIT = 7;
    localparam int ST_W = 8;
    localparam logic REF_PD_RESET = 1'b1;
    localparam logic [SAMPLE_W-1:0] LINE_MID = 6'h00;
    localparam logic [1:0] CFG_EXT_FAST = 2'h0;
    localparam logic [1:0] CFG_EXT_SLOW = 2'h1;
    localparam logic [1:0] CFG_INT_OSC = 2'h2;
    localparam logic [1:0] CFG_INT_OUT = 2'h3;
    localparam logic [2:0] CK_NONE = 3'h0;
    localparam logic [2:0] CK_3M6864 = 3'h1;
    localparam logic [2:0] CK_1M8432 = 3'h2;
    localparam logic [2:0] CK_1M2288 = 3'h3;
    localparam logic [2:0] CK_4M = 3'h4;
    typedef enum logic [3:0] {
        ARB_RX = 4'b0001,
        ARB_TX = 4'b0010,
        ARB_DUPLEX = 4'b0100,
        ARB_WAIT = 4'b1000
    } arb_t;
endpackage

// file: rtl/sine_rom.sv
// one sine cycle of 32 signed samples with registered read data
`timescale 1ns/1ps
module sine_rom
    import modem_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic clkEn,
    input wire logic [IDX_W-1:0] addr,
    output logic [SAMPLE_W-1:0] data
);
    logic [SAMPLE_W-1:0] data_q;
    logic [SAMPLE_W-1:0] data_d;
    logic [SAMPLE_W-1:0] table_c [TABLE_LEN];
    // quarter-wave symmetric table, amplitude 31
    assign table_c = '{6'h00, 6'h06, 6'h0C, 6'h11, 6'h16, 6'h1A, 6'h1D,
        6'h1E, 6'h1F, 6'h1E, 6'h1D, 6'h1A, 6'h16, 6'h11, 6'h0C, 6'h06,
        6'h00, 6'h3A, 6'h34, 6'h2F, 6'h2A, 6'h26, 6'h23, 6'h22, 6'h21,
        6'h22, 6'h23, 6'h26, 6'h2A, 6'h2F, 6'h34, 6'h3A};
    always_comb begin
        data_d = table_c[addr];
    end
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            data_q <= LINE_MID;
        end else if (clkEn) begin
            data_q <= data_d;
        end
    end
    assign data = data_q;
endmodule

// file: rtl/fsk_manchester_modem_core.sv
// modem core: fsk modulator, carrier detect, manchester encoder, arbitration
`timescale 1ns/1ps
module fsk_manchester_modem_core
    import modem_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic clkEn,
    input wire logic interfaceSelPin,
    input wire logic manchesterModePin,
    input wire logic fullDuplexPin,
    input wire logic refEnablePin,
    input wire logic crystal_enable_pin,
    input wire logic clock_select_hi,
    input wire logic clock_select_lo,
    input wire logic uartRtsN,
    input wire logic uartTxd,
    input wire logic rtsBit,
    input wire logic ref_power_down_bit_wr,
    input wire logic refPdWrite,
    input wire logic txFifoValid,
    input wire logic txFifoBit,
    input wire logic [LVL_W-1:0] txFifoLevel,
    input wire logic [LVL_W-1:0] rxFifoLevel,
    input wire logic [LVL_W-1:0] txThreshold,
    input wire logic [LVL_W-1:0] rxThreshold,
    input wire logic line_receive_in,
    input wire logic line_receive_filtered_in,
    input wire logic filterSelPin,
    input wire logic carrierPresent,
    output logic txFifoPop,
    output logic rxFifoPush,
    output logic rxFifoBit,
    output logic uartRxd,
    output logic uartRxdOe,
    output logic carrier_detect_out,
    output logic irqOut,
    output logic [ST_W-1:0] statusBits,
    output logic [SAMPLE_W-1:0] line_transmit_out,
    output logic lineHighImpedance,
    output logic manchesterOut,
    output logic internalRefOn,
    output logic oscEnable,
    output logic [2:0] clock_output_sel,
    output logic txEnable,
    output logic rxEnable
);
    // pin synchronisers: first stage read only by the second
    localparam int NS = 12;
    logic [NS-1:0] pin;
    logic [NS-1:0] s1_q, s2_q;
    assign pin = {interfaceSelPin, manchesterModePin, fullDuplexPin,
        refEnablePin, crystal_enable_pin, clock_select_hi, clock_select_lo,
        uartRtsN, uartTxd, line_receive_in, line_receive_filtered_in,
        carrierPresent};
    genvar gi;
    generate
        for (gi = 0; gi < NS; gi++) begin : g_sync
            // no reset: pins keep flowing in power-down, so the modes
            // latched at release are the real pins, not reset zeros
            always_ff @(posedge clock) begin
                if (clkEn) begin
                    s1_q[gi] <= pin[gi];
                    s2_q[gi] <= s1_q[gi];
                end
            end
        end
    endgenerate
    logic sIf, sMan, sFd, sRefEn, sXen, sCfgHi, sCfgLo;
    logic sRtsN, sTxd, sRx, sRxF, sCarrier;
    assign {sIf, sMan, sFd, sRefEn, sXen, sCfgHi, sCfgLo, sRtsN, sTxd,
        sRx, sRxF, sCarrier} = s2_q;

    // mode latches taken once after reset release
    logic latched_q, latched_d, spi_q, spi_d, man_q, man_d, fd_q, fd_d;
    logic refPd_q, refPd_d;
    always_comb begin
        latched_d = 1'b1;
        spi_d = latched_q ? spi_q : sIf;
        man_d = latched_q ? man_q : sMan;
        fd_d = latched_q ? fd_q : sFd;
        refPd_d = (refPdWrite && spi_q) ? ref_power_down_bit_wr : refPd_q;
    end
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            latched_q <= 1'b0;
            spi_q <= 1'b0;
            man_q <= 1'b0;
            fd_q <= 1'b0;
            refPd_q <= REF_PD_RESET;
        end else if (clkEn) begin
            latched_q <= latched_d;
            spi_q <= spi_d;
            man_q <= man_d;
            fd_q <= fd_d;
            refPd_q <= refPd_d;
        end
    end

    // clock configuration, follows the pins live but is cleared to CK_NONE in reset
    logic oscEn_q, oscEn_d, intOsc;
    logic [2:0] ckSel_q, ckSel_d;
    always_comb begin
        intOsc = 1'b0;
        // only the internal oscillator needs the start-up guard
        oscEn_d = 1'b0;
        ckSel_d = CK_NONE;
        if (!man_q) begin
            if (sXen) begin
                intOsc = ({sCfgHi, sCfgLo} == CFG_INT_OSC)
                    || ({sCfgHi, sCfgLo} == CFG_INT_OUT);
                oscEn_d = intOsc;
                if ({sCfgHi, sCfgLo} == CFG_INT_OUT) begin
                    ckSel_d = CK_1M2288;
                end
            end else begin
                case ({sCfgHi, sCfgLo})
                    CFG_EXT_SLOW: ckSel_d = CK_3M6864;
                    CFG_INT_OSC: ckSel_d = CK_1M8432;
                    CFG_INT_OUT: ckSel_d = CK_1M2288;
                    default: ckSel_d = CK_NONE;
                endcase
            end
        end else if (!sXen && sCfgHi) begin
            ckSel_d = CK_4M;
        end
    end
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            oscEn_q <= 1'b0;
            ckSel_q <= CK_NONE;
        end else if (clkEn) begin
            oscEn_q <= oscEn_d;
            ckSel_q <= ckSel_d;
        end
    end

    // oscillator start-up guard
    logic [CNT_W-1:0] osc_q, osc_d;
    logic oscWasOn_q, ready;
    always_comb begin
        osc_d = osc_q;
        if (oscEn_q && !oscWasOn_q) begin
            osc_d = CNT_W'(OSC_START_CYC);
        end else if (osc_q != '0) begin
            osc_d = osc_q - 1'b1;
        end
    end
    // the start edge itself is not ready, else one cycle slips through
    assign ready = (osc_q == '0) && !(oscEn_q && !oscWasOn_q);
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            osc_q <= '0;
            oscWasOn_q <= 1'b0;
        end else if (clkEn) begin
            osc_q <= osc_d;
            oscWasOn_q <= oscEn_q;
        end
    end

    // carrier detect with on/off delay hysteresis
    logic cd_q, cd_d;
    logic [CNT_W-1:0] cdCnt_q, cdCnt_d;
    always_comb begin
        cd_d = cd_q;
        cdCnt_d = '0;
        if (sCarrier != cd_q) begin
            cdCnt_d = cdCnt_q + 1'b1;
            if (cdCnt_q >= CNT_W'(cd_q ? CD_OFF_CYC : CD_ON_CYC)) begin
                cd_d = sCarrier;
                cdCnt_d = '0;
            end
        end
    end

    // arbitration
    arb_t arb_q, arb_d;
    logic txReq;
    always_comb begin
        txReq = man_q ? txFifoValid
            : (spi_q ? rtsBit : !sRtsN);
        arb_d = arb_q;
        case (arb_q)
            ARB_WAIT: if (ready && latched_q) begin
                arb_d = fd_q ? ARB_DUPLEX : ARB_RX;
            end
            ARB_RX: if (txReq && !cd_q) begin
                arb_d = ARB_TX;
            end
            ARB_TX: if (!txReq) begin
                arb_d = ARB_RX;
            end
            ARB_DUPLEX: arb_d = ARB_DUPLEX;
            default: arb_d = ARB_WAIT;
        endcase
        if (!ready) begin
            arb_d = ARB_WAIT;
        end
    end

    // fsk phase accumulator and manchester encoder
    logic [IDX_W-1:0] idx_q, idx_d;
    logic [CNT_W-1:0] div_q, div_d;
    logic [CNT_W-1:0] bitCnt_q, bitCnt_d;
    logic half_q, half_d, manOut_q, manOut_d, curBit_q, curBit_d;
    logic pop_d, txOn;
    assign txOn = (arb_q == ARB_TX) || (arb_q == ARB_DUPLEX);
    always_comb begin
        idx_d = idx_q;
        div_d = div_q;
        bitCnt_d = bitCnt_q;
        half_d = half_q;
        manOut_d = manOut_q;
        curBit_d = curBit_q;
        pop_d = 1'b0;
        if (txOn && !man_q) begin
            // uart bit drives the tone directly; fifo bit in spi
            curBit_d = spi_q ? txFifoBit : sTxd;
            if (div_q == '0) begin
                // reload one short: the zero cycle ends the period
                div_d = CNT_W'((curBit_q ? MARK_STEP : SPACE_STEP)
                    - 1);
                idx_d = idx_q + 1'b1;
            end else begin
                div_d = div_q - 1'b1;
            end
            if (spi_q) begin
                if (bitCnt_q == '0) begin
                    bitCnt_d = CNT_W'(FSK_BIT - 1);
                    pop_d = txFifoValid;
                end else begin
                    bitCnt_d = bitCnt_q - 1'b1;
                end
            end
        end else if (txOn && man_q) begin
            if (bitCnt_q == '0) begin
                bitCnt_d = CNT_W'(MAN_HALF - 1);
                half_d = !half_q;
                if (!half_q) begin
                    curBit_d = txFifoBit;
                    pop_d = txFifoValid;
                    manOut_d = txFifoBit;
                end else begin
                    manOut_d = !curBit_q;
                end
            end else begin
                bitCnt_d = bitCnt_q - 1'b1;
            end
        end else begin
            div_d = '0;
            bitCnt_d = '0;
            half_d = 1'b0;
        end
    end
    logic [SAMPLE_W-1:0] sample;
    sine_rom u_rom (
        .clock(clock),
        .nrst(nrst),
        .clkEn(clkEn),
        .addr(idx_q),
        .data(sample)
    );

    // receive and status outputs
    logic rxOn, rxBit, rxPush_d, rxd_d, cdOut_d, irq_d;
    logic [ST_W-1:0] st_d;
    logic txLow, rxHigh;
    assign rxOn = (arb_q == ARB_RX) || (arb_q == ARB_DUPLEX);
    assign rxBit = filterSelPin ? sRxF : sRx;
    assign txLow = txFifoLevel < txThreshold;
    assign rxHigh = rxFifoLevel >= rxThreshold;
    always_comb begin
        rxPush_d = rxOn && spi_q && cd_q;
        rxd_d = (rxOn && !spi_q) ? rxBit : 1'b1;
        st_d = '0;
        st_d[ST_CD_BIT] = cd_q && !man_q;
        st_d[ST_TXLVL_BIT] = man_q && txLow;
        st_d[ST_RXRDY_BIT] = man_q && rxHigh;
        irq_d = spi_q && (st_d != '0);
        cdOut_d = !spi_q && (man_q ? txLow : cd_q);
    end
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            cd_q <= 1'b0;
            cdCnt_q <= '0;
            arb_q <= ARB_WAIT;
            idx_q <= '0;
            div_q <= '0;
            bitCnt_q <= '0;
            half_q <= 1'b0;
            manOut_q <= 1'b0;
            curBit_q <= 1'b1;
            txFifoPop <= 1'b0;
            rxFifoPush <= 1'b0;
            rxFifoBit <= 1'b0;
            uartRxd <= 1'b1;
            uartRxdOe <= 1'b0;
            carrier_detect_out <= 1'b0;
            irqOut <= 1'b0;
            statusBits <= '0;
            line_transmit_out <= LINE_MID;
            lineHighImpedance <= 1'b1;
            manchesterOut <= 1'b0;
            internalRefOn <= 1'b0;
            oscEnable <= 1'b0;
            clock_output_sel <= CK_NONE;
            txEnable <= 1'b0;
            rxEnable <= 1'b0;
        end else if (clkEn) begin
            cd_q <= cd_d;
            cdCnt_q <= cdCnt_d;
            arb_q <= arb_d;
            idx_q <= idx_d;
            div_q <= div_d;
            bitCnt_q <= bitCnt_d;
            half_q <= half_d;
            manOut_q <= manOut_d;
            curBit_q <= curBit_d;
            txFifoPop <= pop_d;
            rxFifoPush <= rxPush_d;
            rxFifoBit <= rxBit;
            uartRxd <= rxd_d;
            uartRxdOe <= !spi_q && latched_q;
            carrier_detect_out <= cdOut_d;
            irqOut <= irq_d;
            statusBits <= st_d;
            line_transmit_out <= (txOn && !man_q) ? sample : LINE_MID;
            lineHighImpedance <= !txOn;
            manchesterOut <= txOn && man_q && manOut_q;
            // the pin alone decides; the software bit cannot override it
            internalRefOn <= sRefEn;
            oscEnable <= oscEn_q;
            clock_output_sel <= ckSel_q;
            txEnable <= txOn;
            rxEnable <= rxOn;
        end
    end
endmodule

// file: verif/line_partner.sv
// far side of the line: idle noise, or an echo in self-test
`timescale 1ns/1ps
module line_partner (
    input wire logic clock,
    input wire logic nrst,
    input wire logic loopBack,
    input wire logic txBit,
    output logic rxRaw,
    output logic rxFilt,
    output logic carrier
);
    logic noise_q;
    logic noise_d;
    always_comb begin
        noise_d = ~noise_q;
    end
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            noise_q <= 1'b0;
        end else begin
            noise_q <= noise_d;
        end
    end
    // a quiet line must not look settled, so it toggles every cycle
    assign rxRaw = loopBack ? txBit : noise_q;
    assign rxFilt = loopBack ? txBit : ~noise_q;
    // no tone is put on the line
    assign carrier = 1'b0;
endmodule

// file: verif/modem_core_checker.sv
// assertions on the modem core ports
`timescale 1ns/1ps
module modem_core_checker
    import modem_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic interfaceSelPin,
    input wire logic manchesterModePin,
    input wire logic fullDuplexPin,
    input wire logic refEnablePin,
    input wire logic crystal_enable_pin,
    input wire logic clock_select_hi,
    input wire logic clock_select_lo,
    input wire logic txFifoBit,
    input wire logic [LVL_W-1:0] txFifoLevel,
    input wire logic [LVL_W-1:0] txThreshold,
    input wire logic txFifoPop,
    input wire logic uartRxd,
    input wire logic irqOut,
    input wire logic [ST_W-1:0] statusBits,
    input wire logic lineHighImpedance,
    input wire logic manchesterOut,
    input wire logic internalRefOn,
    input wire logic [2:0] clock_output_sel,
    input wire logic txEnable,
    input wire logic rxEnable
);
    logic [3:0] age_q;
    logic [3:0] age_d;
    logic [12:0] pop_q;
    logic [12:0] pop_d;
    logic bit_q;
    logic bit_d;
    logic seen_q;
    logic seen_d;
    logic spiMan;
    always_comb begin
        age_d = (age_q == 4'hF) ? age_q : age_q + 4'h1;
        pop_d = (pop_q == 13'h1FFF) ? pop_q : pop_q + 13'h1;
        bit_d = bit_q;
        seen_d = seen_q;
        if (txFifoPop) begin
            pop_d = 13'h0;
            bit_d = txFifoBit;
            seen_d = 1'b1;
        end
    end
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            age_q <= 4'h0;
            pop_q <= 13'h0;
            bit_q <= 1'b0;
            seen_q <= 1'b0;
        end else begin
            age_q <= age_d;
            pop_q <= pop_d;
            bit_q <= bit_d;
            seen_q <= seen_d;
        end
    end
    assign spiMan = age_q == 4'hF && interfaceSelPin && manchesterModePin;
    // mid-level on the low pin cannot be seen, so manchester uses hi only
    function automatic logic [2:0] clkExp(input logic [1:0] cfg);
        if (manchesterModePin)
            return (cfg[1] && !crystal_enable_pin) ? CK_4M : CK_NONE;
        if (crystal_enable_pin) return cfg[0] & cfg[1] ? CK_1M2288 : CK_NONE;
        case (cfg)
            2'h1: return CK_3M6864;
            2'h2: return CK_1M8432;
            2'h3: return CK_1M2288;
            default: return CK_NONE;
        endcase
    endfunction
    default clocking cb @(posedge clock);
    endclocking
    sequence s_settled;
        age_q == 4'hF;
    endsequence
    sequence s_first_half;
        seen_q && manchesterModePin && pop_q == 13'(MAN_HALF / 2);
    endsequence
    sequence s_second_half;
        seen_q && manchesterModePin && pop_q == 13'(MAN_HALF * 3 / 2);
    endsequence
    a_paths_exclusive: assert property (
        disable iff (!nrst) !fullDuplexPin |-> !(txEnable && rxEnable))
        else $error("both paths on");
    a_reset_quiet: assert property (
        !nrst [*2] |-> lineHighImpedance && uartRxd && !txEnable
        && !rxEnable && !internalRefOn && clock_output_sel == CK_NONE)
        else $error("not quiet in reset");
    a_ref_select: assert property (
        disable iff (!nrst) s_settled |-> internalRefOn == refEnablePin)
        else $error("wrong reference");
    a_clock_select: assert property (
        disable iff (!nrst) s_settled |-> clock_output_sel
        == clkExp({clock_select_hi, clock_select_lo}))
        else $error("wrong clock output");
    a_first_half: assert property (
        disable iff (!nrst) s_first_half |-> manchesterOut == bit_q)
        else $error("first half wrong");
    a_second_half: assert property (
        disable iff (!nrst) s_second_half |-> manchesterOut == !bit_q)
        else $error("second half wrong");
    a_pop_spacing: assert property (
        disable iff (!nrst) txFifoPop && seen_q && manchesterModePin
        |-> pop_q >= 13'(2 * MAN_HALF - 1))
        else $error("bits too close");
    a_txlvl_status: assert property (
        disable iff (!nrst) (spiMan && $stable(txFifoLevel)
        && $stable(txThreshold)) [*3] |-> statusBits[ST_TXLVL_BIT]
        == (txFifoLevel < txThreshold))
        else $error("tx level bit wrong");
    a_rxrdy_irq: assert property (
        disable iff (!nrst) spiMan && statusBits[ST_RXRDY_BIT]
        |-> ##[0:2] irqOut)
        else $error("no irq for rx ready");
    a_duplex_both: assert property (
        disable iff (!nrst) s_settled ##0 fullDuplexPin
        |-> txEnable && rxEnable)
        else $error("duplex paths off");
endmodule
bind fsk_manchester_modem_core modem_core_checker i_checker (
    .clock, .nrst, .interfaceSelPin, .manchesterModePin, .fullDuplexPin,
    .refEnablePin, .crystal_enable_pin, .clock_select_hi, .clock_select_lo,
    .txFifoBit, .txFifoLevel, .txThreshold, .txFifoPop, .uartRxd, .irqOut,
    .statusBits, .lineHighImpedance, .manchesterOut, .internalRefOn,
    .clock_output_sel, .txEnable, .rxEnable
);

// file: verif/tb_fsk_manchester_modem_core.sv
// self-checking bench for the modem core
`timescale 1ns/1ps
module tb_fsk_manchester_modem_core
    import modem_pkg::*;
;
    logic clock, nrst, clkEn, interfaceSelPin, manchesterModePin;
    logic fullDuplexPin, refEnablePin, crystal_enable_pin, clock_select_hi;
    logic clock_select_lo, uartRtsN, uartTxd, rtsBit, ref_power_down_bit_wr;
    logic refPdWrite, txFifoValid, txFifoBit, filterSelPin, carrierPresent;
    logic [LVL_W-1:0] txFifoLevel, rxFifoLevel, txThreshold, rxThreshold;
    logic line_receive_in, line_receive_filtered_in, txFifoPop, uartRxd;
    logic uartRxdOe, irqOut, lineHighImpedance, manchesterOut;
    logic internalRefOn, oscEnable, txEnable, rxEnable;
    logic [ST_W-1:0] statusBits;
    logic [2:0] clock_output_sel;
    logic carrier_detect_out;
    logic [SAMPLE_W-1:0] line_transmit_out;
    int gap;
    logic [2:0] clkTab [8] = '{CK_NONE, CK_3M6864, CK_1M8432, CK_1M2288,
        CK_NONE, CK_NONE, CK_NONE, CK_1M2288};
    int failures;
    int checks_done;
    fsk_manchester_modem_core i_dut (
        .clock, .nrst, .clkEn, .interfaceSelPin, .manchesterModePin,
        .fullDuplexPin, .refEnablePin, .crystal_enable_pin, .clock_select_hi,
        .clock_select_lo, .uartRtsN, .uartTxd, .rtsBit, .ref_power_down_bit_wr,
        .refPdWrite, .txFifoValid, .txFifoBit, .txFifoLevel, .rxFifoLevel,
        .txThreshold, .rxThreshold, .line_receive_in,
        .line_receive_filtered_in, .filterSelPin, .carrierPresent,
        .txFifoPop, .rxFifoPush(), .rxFifoBit(), .uartRxd, .uartRxdOe,
        .carrier_detect_out, .irqOut, .statusBits, .line_transmit_out,
        .lineHighImpedance, .manchesterOut,
        .internalRefOn, .oscEnable, .clock_output_sel, .txEnable, .rxEnable
    );
    line_partner i_line (
        .clock, .nrst, .loopBack(fullDuplexPin), .txBit(manchesterOut),
        .rxRaw(line_receive_in), .rxFilt(line_receive_filtered_in),
        .carrier(carrierPresent)
    );
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: saw %h not %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        if (failures == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // mode pins only take effect across a reset, so every mode restarts
    task automatic restart(input logic [6:0] pins);
        @(posedge clock);
        nrst <= 1'b0;
        {interfaceSelPin, manchesterModePin, fullDuplexPin, refEnablePin,
            crystal_enable_pin, clock_select_hi, clock_select_lo} <= pins;
        repeat (5) @(posedge clock);
        nrst <= 1'b1;
        repeat (20) @(posedge clock);
        #1;
    endtask
    task automatic await(ref logic sig, input logic lvl, input int lim);
        for (int n = 0; n < lim && sig !== lvl; n++) begin
            @(posedge clock);
            #1;
        end
    endtask
    // cycles between two sample steps, after the next step is seen
    task automatic step_gap(output int gap);
        logic [SAMPLE_W-1:0] last;
        gap = 0;
        last = line_transmit_out;
        for (int n = 0; n < 3000 && line_transmit_out === last; n++) begin
            @(posedge clock);
            #1;
        end
        last = line_transmit_out;
        while (gap < 3000 && line_transmit_out === last) begin
            @(posedge clock);
            #1;
            gap++;
        end
    endtask
    initial begin
        repeat (60000) @(posedge clock);
        failures++;
        complete_run();
    end
    initial begin
        failures = 0;
        checks_done = 0;
        {nrst, interfaceSelPin, manchesterModePin, fullDuplexPin} = '0;
        {refEnablePin, crystal_enable_pin, clock_select_hi} = '0;
        {clock_select_lo, rtsBit, ref_power_down_bit_wr, refPdWrite} = '0;
        {txFifoValid, txFifoBit, filterSelPin} = '0;
        {txFifoLevel, rxFifoLevel, txThreshold, rxThreshold} = '0;
        {clkEn, uartRtsN, uartTxd} = 3'h7;
        repeat (3) @(posedge clock);
        #1;
        check({uartRxd, lineHighImpedance, txEnable, rxEnable, internalRefOn,
            uartRxdOe, irqOut, manchesterOut}, 8'hC0);
        for (int k = 0; k < 8; k++) begin
            restart({3'h0, k[0], k[2:0]});
            check(8'(clock_output_sel), 8'(clkTab[k]));
            check(8'({oscEnable, internalRefOn}),
                8'({k[2] & k[1], k[0]}));
        end
        for (int j = 0; j < 2; j++) begin
            restart({4'h4, j[0], 2'h2});
            check(8'(clock_output_sel), 8'(j ? CK_NONE : CK_4M));
        end
        check(8'(carrier_detect_out), 8'h00);
        @(posedge clock);
        txThreshold <= 4'h1;
        repeat (3) @(posedge clock);
        #1;
        check(8'(carrier_detect_out), 8'h01);
        restart(7'h00);
        check(8'({txEnable, rxEnable}), 8'h01);
        @(posedge clock);
        uartRtsN <= 1'b0;
        uartTxd <= 1'b0;
        await(txEnable, 1'b1, 50);
        check(8'({txEnable, rxEnable}), 8'h02);
        @(posedge clock);
        interfaceSelPin <= 1'b1;
        repeat (20) @(posedge clock);
        #1;
        check(8'(txEnable), 8'h01);
        step_gap(gap);
        check(8'(gap == SPACE_STEP), 8'h01);
        @(posedge clock);
        uartTxd <= 1'b1;
        step_gap(gap);
        step_gap(gap);
        check(8'(gap == MARK_STEP), 8'h01);
        @(posedge clock);
        uartRtsN <= 1'b1;
        await(rxEnable, 1'b1, 50);
        check(8'({txEnable, rxEnable}), 8'h01);
        restart(7'h60);
        @(posedge clock);
        {txFifoLevel, txThreshold, rxFifoLevel, rxThreshold} <= 16'h2433;
        refPdWrite <= 1'b1;
        @(posedge clock);
        refPdWrite <= 1'b0;
        repeat (5) @(posedge clock);
        #1;
        check(statusBits & 8'h92, 8'h90);
        check(8'({irqOut, internalRefOn}), 8'h02);
        @(posedge clock);
        {txFifoLevel, rxFifoLevel} <= 8'h42;
        repeat (5) @(posedge clock);
        #1;
        check(8'({statusBits[7], statusBits[4], irqOut}),
            8'h00);
        for (int i = 0; i < 2; i++) begin
            @(posedge clock);
            txFifoValid <= 1'b1;
            txFifoBit <= i[0];
            await(txFifoPop, 1'b1, 4000);
            repeat (MAN_HALF / 2) @(posedge clock);
            #1;
            check(8'({txEnable, manchesterOut}),
                8'({1'b1, i[0]}));
            repeat (MAN_HALF) @(posedge clock);
            #1;
            check(8'(manchesterOut), 8'(!i[0]));
        end
        @(posedge clock);
        txFifoValid <= 1'b0;
        await(txEnable, 1'b0, 4000);
        check(8'({txEnable, rxEnable}), 8'h01);
        restart(7'h10);
        @(posedge clock);
        filterSelPin <= 1'b1;
        repeat (3) @(posedge clock);
        #1;
        check(8'({txEnable, rxEnable}), 8'h03);
        complete_run();
    end
endmodule
